// ### inc/rtc_alarm_defs.vh
`ifndef RTC_ALARM_DEFS_VH
`define RTC_ALARM_DEFS_VH

// register offsets
`define OFS_CTRL1 8'h00
`define OFS_CTRL2 8'h01
`define OFS_SEC 8'h02
`define OFS_MIN 8'h03
`define OFS_HOUR 8'h04
`define OFS_DATE 8'h05
`define OFS_WDAY 8'h06
`define OFS_AL_MIN 8'h09
`define OFS_AL_HOUR 8'h0A
`define OFS_AL_DATE 8'h0B
`define OFS_AL_WDAY 8'h0C

// first control/status register bits
`define BIT_EXTERNAL_TICK_TEST_ENABLE 7
`define BIT_STOP 5
`define BIT_RESET_OVERRIDE_PERMIT 3
// second control/status register bits
`define BIT_PULSE_SEL 4
`define BIT_AF 3
`define BIT_TF 2
`define BIT_AIE 1
`define BIT_TIE 0
// top bit of seconds and alarm registers
`define BIT_TOP 7

// field masks of the counted and alarm registers
`define MASK_MIN 8'h7F
`define MASK_HOUR 8'h3F
`define MASK_DATE 8'h3F
`define MASK_WDAY 8'h07
// alarm fields keep their disable bit on top of the value
`define MASK_AL_HOUR 8'hBF
`define MASK_AL_DATE 8'hBF
`define MASK_AL_WDAY 8'h87

// counting limits (bcd)
`define SEC_LAST 8'h59
`define MIN_LAST 8'h59
`define HOUR_LAST 8'h23
`define DATE_LAST 8'h31
`define DATE_FIRST 8'h01
`define WDAY_LAST 8'h06
`define ZERO_BYTE 8'h00

// two-wire slave address, without direction bit
`define SLAVE_ADDR 7'h51
// pre-scaler value on whose edge the second increments
`define PRESCALE_HALF 6'h1F
// reset values
`define CTRL1_RESET 8'h08
`define SEC_RESET 8'h80
// clock falls with data low that make an override sequence
`define OVR_FALLS 4

`endif

// ### design/byte_fifo.v
`default_nettype none
// small synchronous fifo, valid/ready on both sides
module byte_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk,
  input wire reset_n,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  // full and empty come straight from the occupancy count
  assign in_ready = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // pointers wrap at depth, which need not be a power of two
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (push & ~pop)
        count_reg <= count_reg + 1'b1;
      else if (pop & ~push)
        count_reg <= count_reg - 1'b1;
    end
  end

  // storage has no reset; only written slots are ever read
  always @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end
endmodule
`default_nettype wire

// ### design/rtc_alarm_i2c.v
`include "rtc_alarm_defs.vh"
`default_nettype none
// alarm, external tick test mode, reset override and two-wire slave
module rtc_alarm_i2c #(
  parameter FIFO_DEPTH = 4,
  parameter OVR_COUNT = `OVR_FALLS
) (
  input wire clk,
  input wire reset_n,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire square_wave_in,
  output reg square_wave_out,
  output reg square_wave_oe,
  input wire tick_64hz,
  input wire por_active,
  output reg device_held,
  output reg alarm_int_n
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ADDR_ACK = 3'd2;
  localparam ST_WRITE = 3'd3;
  localparam ST_WRITE_ACK = 3'd4;
  localparam ST_READ = 3'd5;
  localparam ST_READ_ACK = 3'd6;
  localparam ST_START = 3'd7;
  localparam [7:0] CTRL1_INIT = `CTRL1_RESET;

  // two-stage synchronisers plus one delay stage for edges
  reg [2:0] scl_sync_reg;
  reg [2:0] sda_sync_reg;
  reg [2:0] sqw_sync_reg;
  reg [2:0] tick_sync_reg;
  reg [1:0] por_sync_reg;

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      sqw_sync_reg <= 3'h0;
      tick_sync_reg <= 3'h0;
      por_sync_reg <= 2'h3;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      sqw_sync_reg <= {sqw_sync_reg[1:0], square_wave_in};
      tick_sync_reg <= {tick_sync_reg[1:0], tick_64hz};
      por_sync_reg <= {por_sync_reg[0], por_active};
    end
  end

  wire scl_s = scl_sync_reg[1];
  wire scl_d = scl_sync_reg[2];
  wire sda_s = sda_sync_reg[1];
  wire sda_d = sda_sync_reg[2];
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  // data edges with the clock high on both samples are bus conditions
  wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
  wire bus_stop = scl_s & scl_d & ~sda_d & sda_s;

  // register file
  reg external_tick_test_enable_reg;
  reg stop_reg;
  reg reset_override_permit_reg;
  reg pulse_sel_reg;
  reg af_reg;
  reg tf_reg;
  reg aie_reg;
  reg tie_reg;
  reg [7:0] sec_reg;
  reg [7:0] min_reg;
  reg [7:0] hour_reg;
  reg [7:0] date_reg;
  reg [7:0] wday_reg;
  reg [7:0] al_min_reg;
  reg [7:0] al_hour_reg;
  reg [7:0] al_date_reg;
  reg [7:0] al_wday_reg;
  reg [7:0] pointer_reg;
  reg [5:0] prescale_reg;
  reg match_prev_reg;
  reg override_reg;
  reg [2:0] ovr_cnt_reg;

  // slave state
  reg [2:0] state_reg;
  reg [2:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] tx_reg;
  reg first_byte_reg;

  // write path through the fifo: bit 8 marks a pointer byte
  wire [8:0] fifo_in_data = {first_byte_reg, shift_reg};
  wire fifo_in_valid;
  wire fifo_in_ready;
  wire [8:0] fifo_out_data;
  wire fifo_out_valid;
  wire fifo_out_ready;

  // tick source: pin edges replace the internal tick in test mode
  wire tick_level = external_tick_test_enable_reg ? sqw_sync_reg[1] : tick_sync_reg[1];
  wire tick_prev = external_tick_test_enable_reg ? sqw_sync_reg[2] : tick_sync_reg[2];
  wire tick_rise = tick_level & ~tick_prev & ~device_held;
  // seconds step when the pre-scaler passes its half-way value
  wire sec_step = tick_rise & ~stop_reg & (prescale_reg == `PRESCALE_HALF);

  // the drain stalls in the step cycle so counter and bus never collide
  assign fifo_out_ready = ~sec_step;

  byte_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH),
    .AW(2)
  ) write_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_data(fifo_in_data),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready)
  );

  wire drain = fifo_out_valid & fifo_out_ready;
  wire drain_ptr = drain & fifo_out_data[8];
  wire drain_wr = drain & ~fifo_out_data[8];
  wire [7:0] wdata = fifo_out_data[7:0];

  // bcd increment with wrap from last back to first
  function [7:0] bcd_next;
    input [7:0] v;
    input [7:0] last;
    input [7:0] first;
    begin
      if (v == last)
        bcd_next = first;
      else if (v[3:0] == 4'h9)
        bcd_next = {v[7:4] + 4'h1, 4'h0};
      else
        bcd_next = v + 8'h01;
    end
  endfunction

  // next seconds value; the top bit is the oscillator flag and stays
  wire [7:0] sec_inc = bcd_next({1'b0, sec_reg[6:0]}, `SEC_LAST, `ZERO_BYTE);

  // read mux; unused bits and unmapped addresses read zero
  reg [7:0] rd_data;
  always @*
  begin
    rd_data = `ZERO_BYTE;
    case (pointer_reg)
      `OFS_CTRL1: rd_data = {external_tick_test_enable_reg, 1'b0, stop_reg, 1'b0, reset_override_permit_reg, 3'h0};
      `OFS_CTRL2: rd_data = {3'h0, pulse_sel_reg, af_reg, tf_reg, aie_reg, tie_reg};
      `OFS_SEC: rd_data = sec_reg;
      `OFS_MIN: rd_data = min_reg & `MASK_MIN;
      `OFS_HOUR: rd_data = hour_reg & `MASK_HOUR;
      `OFS_DATE: rd_data = date_reg & `MASK_DATE;
      `OFS_WDAY: rd_data = wday_reg & `MASK_WDAY;
      `OFS_AL_MIN: rd_data = al_min_reg;
      `OFS_AL_HOUR: rd_data = al_hour_reg & `MASK_AL_HOUR;
      `OFS_AL_DATE: rd_data = al_date_reg & `MASK_AL_DATE;
      `OFS_AL_WDAY: rd_data = al_wday_reg & `MASK_AL_WDAY;
      default: rd_data = `ZERO_BYTE;
    endcase
  end

  // a field with its top bit set is left out and counts as matching
  wire m_min = al_min_reg[`BIT_TOP] | ((al_min_reg & `MASK_MIN) == (min_reg & `MASK_MIN));
  wire m_hour = al_hour_reg[`BIT_TOP] | ((al_hour_reg & `MASK_HOUR) == (hour_reg & `MASK_HOUR));
  wire m_date = al_date_reg[`BIT_TOP] | ((al_date_reg & `MASK_DATE) == (date_reg & `MASK_DATE));
  wire m_wday = al_wday_reg[`BIT_TOP] | ((al_wday_reg & `MASK_WDAY) == (wday_reg & `MASK_WDAY));
  // all four disabled never raises the flag
  wire any_enabled = ~(al_min_reg[`BIT_TOP] & al_hour_reg[`BIT_TOP] &
    al_date_reg[`BIT_TOP] & al_wday_reg[`BIT_TOP]);
  wire match_all = m_min & m_hour & m_date & m_wday & any_enabled;

  // pre-scaler: held at zero while stopped; not cleared on test entry,
  // so its contents after entering test mode must be taken as unknown
  always @(posedge clk)
  begin
    if (!reset_n)
      prescale_reg <= 6'h00;
    else if (stop_reg)
      prescale_reg <= 6'h00;
    else if (tick_rise)
      prescale_reg <= prescale_reg + 6'h01;
  end

  // control registers, written from the fifo drain
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      external_tick_test_enable_reg <= CTRL1_INIT[`BIT_EXTERNAL_TICK_TEST_ENABLE];
      stop_reg <= CTRL1_INIT[`BIT_STOP];
      reset_override_permit_reg <= CTRL1_INIT[`BIT_RESET_OVERRIDE_PERMIT];
      pulse_sel_reg <= 1'b0;
      tf_reg <= 1'b0;
      aie_reg <= 1'b0;
      tie_reg <= 1'b0;
    end
    else if (drain_wr && pointer_reg == `OFS_CTRL1)
    begin
      external_tick_test_enable_reg <= wdata[`BIT_EXTERNAL_TICK_TEST_ENABLE];
      stop_reg <= wdata[`BIT_STOP];
      reset_override_permit_reg <= wdata[`BIT_RESET_OVERRIDE_PERMIT];
    end
    else if (drain_wr && pointer_reg == `OFS_CTRL2)
    begin
      pulse_sel_reg <= wdata[`BIT_PULSE_SEL];
      tf_reg <= tf_reg & wdata[`BIT_TF];
      aie_reg <= wdata[`BIT_AIE];
      tie_reg <= wdata[`BIT_TIE];
    end
  end

  // alarm flag: set on a fresh match, a zero write clears, set wins
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      af_reg <= 1'b0;
      match_prev_reg <= 1'b0;
    end
    else
    begin
      match_prev_reg <= match_all;
      if (match_all & ~match_prev_reg)
        af_reg <= 1'b1;
      else if (drain_wr && pointer_reg == `OFS_CTRL2 && !wdata[`BIT_AF])
        af_reg <= 1'b0;
    end
  end

  // time counters and alarm registers; a step wins and writes wait in the fifo
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      sec_reg <= `SEC_RESET;
      min_reg <= `ZERO_BYTE;
      hour_reg <= `ZERO_BYTE;
      date_reg <= `DATE_FIRST;
      wday_reg <= `ZERO_BYTE;
      al_min_reg <= `ZERO_BYTE;
      al_hour_reg <= `ZERO_BYTE;
      al_date_reg <= `ZERO_BYTE;
      al_wday_reg <= `ZERO_BYTE;
    end
    else if (sec_step)
    begin
      sec_reg[6:0] <= sec_inc[6:0];
      if (sec_reg[6:0] == `SEC_LAST)
      begin
        min_reg <= bcd_next(min_reg & `MASK_MIN, `MIN_LAST, `ZERO_BYTE);
        if ((min_reg & `MASK_MIN) == `MIN_LAST)
        begin
          hour_reg <= bcd_next(hour_reg & `MASK_HOUR, `HOUR_LAST, `ZERO_BYTE);
          if ((hour_reg & `MASK_HOUR) == `HOUR_LAST)
          begin
            date_reg <= bcd_next(date_reg & `MASK_DATE, `DATE_LAST, `DATE_FIRST);
            wday_reg <= bcd_next(wday_reg & `MASK_WDAY, `WDAY_LAST, `ZERO_BYTE);
          end
        end
      end
    end
    else if (drain_wr)
    begin
      case (pointer_reg)
        `OFS_SEC: sec_reg <= wdata;
        `OFS_MIN: min_reg <= wdata & `MASK_MIN;
        `OFS_HOUR: hour_reg <= wdata & `MASK_HOUR;
        `OFS_DATE: date_reg <= wdata & `MASK_DATE;
        `OFS_WDAY: wday_reg <= wdata & `MASK_WDAY;
        `OFS_AL_MIN: al_min_reg <= wdata;
        `OFS_AL_HOUR: al_hour_reg <= wdata & `MASK_AL_HOUR;
        `OFS_AL_DATE: al_date_reg <= wdata & `MASK_AL_DATE;
        `OFS_AL_WDAY: al_wday_reg <= wdata & `MASK_AL_WDAY;
        default: sec_reg <= sec_reg;
      endcase
    end
  end

  // reset override: clock falls with data held low while reset lasts
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      override_reg <= 1'b0;
      ovr_cnt_reg <= 3'h0;
    end
    else if (!reset_override_permit_reg)
    begin
      override_reg <= 1'b0;
      ovr_cnt_reg <= 3'h0;
    end
    else if (por_sync_reg[1] && !override_reg)
    begin
      if (sda_s)
        ovr_cnt_reg <= 3'h0;
      else if (scl_fall && ovr_cnt_reg == OVR_COUNT[2:0] - 3'h1)
        override_reg <= 1'b1;
      else if (scl_fall)
        ovr_cnt_reg <= ovr_cnt_reg + 3'h1;
    end
  end

  // the write fifo is filled at the eighth fall of a data byte
  assign fifo_in_valid = (state_reg == ST_WRITE) & scl_fall & (bit_cnt_reg == 3'h7);

  // register pointer: loaded by the first write byte, then advances
  always @(posedge clk)
  begin
    if (!reset_n)
      pointer_reg <= `ZERO_BYTE;
    else if (drain_ptr)
      pointer_reg <= wdata;
    else if (drain_wr)
      pointer_reg <= pointer_reg + 8'h01;
    else if (scl_fall && (state_reg == ST_READ_ACK ||
      (state_reg == ST_ADDR_ACK && shift_reg[0])))
      pointer_reg <= pointer_reg + 8'h01;
  end

  // hold one cycle ahead, so data is let go in the cycle the hold begins
  wire held_next = por_sync_reg[1] & ~override_reg;

  // two-wire slave; a start from any state restarts the address phase
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 3'h0;
      shift_reg <= `ZERO_BYTE;
      tx_reg <= `ZERO_BYTE;
      first_byte_reg <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (held_next || bus_stop)
    begin
      state_reg <= ST_IDLE;
      sda_oe <= 1'b0;
    end
    else if (bus_start)
    begin
      state_reg <= ST_START;
      bit_cnt_reg <= 3'h0;
      sda_oe <= 1'b0;
    end
    else
    begin
      case (state_reg)
        // the clock fall that closes a start carries no data bit
        ST_START:
        begin
          if (scl_fall)
          begin
            state_reg <= ST_ADDR;
            bit_cnt_reg <= 3'h0;
          end
        end
        ST_ADDR, ST_WRITE:
        begin
          if (scl_rise)
            shift_reg <= {shift_reg[6:0], sda_s};
          if (scl_fall)
          begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7 && state_reg == ST_ADDR)
            begin
              if (shift_reg[7:1] == `SLAVE_ADDR)
              begin
                state_reg <= ST_ADDR_ACK;
                sda_oe <= 1'b1;
              end
              else
                state_reg <= ST_IDLE;
            end
            else if (bit_cnt_reg == 3'h7)
            begin
              // a full fifo refuses the byte with a missing acknowledge
              state_reg <= fifo_in_ready ? ST_WRITE_ACK : ST_IDLE;
              sda_oe <= fifo_in_ready;
            end
          end
        end
        ST_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt_reg <= 3'h0;
            first_byte_reg <= 1'b1;
            if (shift_reg[0])
            begin
              state_reg <= ST_READ;
              tx_reg <= rd_data;
              sda_oe <= ~rd_data[7];
            end
            else
            begin
              state_reg <= ST_WRITE;
              sda_oe <= 1'b0;
            end
          end
        end
        ST_WRITE_ACK:
        begin
          if (scl_fall)
          begin
            state_reg <= ST_WRITE;
            first_byte_reg <= 1'b0;
            bit_cnt_reg <= 3'h0;
            sda_oe <= 1'b0;
          end
        end
        ST_READ:
        begin
          if (scl_fall)
          begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7)
            begin
              state_reg <= ST_READ_ACK;
              sda_oe <= 1'b0;
            end
            else
            begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              sda_oe <= ~tx_reg[6];
            end
          end
        end
        ST_READ_ACK:
        begin
          if (scl_rise && sda_s)
            state_reg <= ST_IDLE;
          else if (scl_fall)
          begin
            state_reg <= ST_READ;
            bit_cnt_reg <= 3'h0;
            tx_reg <= rd_data;
            sda_oe <= ~rd_data[7];
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // pin and status outputs, all registered
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      sda_out <= 1'b0;
      square_wave_out <= 1'b0;
      square_wave_oe <= 1'b1;
      device_held <= 1'b1;
      alarm_int_n <= 1'b1;
    end
    else
    begin
      sda_out <= 1'b0; // open drain: only the enable moves
      square_wave_out <= tick_sync_reg[1];
      square_wave_oe <= ~external_tick_test_enable_reg;
      device_held <= held_next;
      alarm_int_n <= ~(af_reg & aie_reg);
    end
  end
endmodule
`default_nettype wire

// ### sim/rtc_alarm_i2c_properties.sv
`include "rtc_alarm_defs.vh"
`default_nettype none
// pin-level checks of the two-wire slave and the power-on hold
module rtc_alarm_i2c_checker #(
  parameter FIFO_DEPTH = 4,
  parameter OVR_COUNT = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic square_wave_in,
  input wire logic square_wave_out,
  input wire logic square_wave_oe,
  input wire logic tick_64hz,
  input wire logic por_active,
  input wire logic device_held,
  input wire logic alarm_int_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] s_scl;
  logic [1:0] s_sda;
  logic [3:0] nfall;
  logic [7:0] shift;
  logic [7:0] addr;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // own view of the bus, counting clock falls since the last start; saturates at 15
  always_ff @(posedge clk)
  begin
    s_scl <= {s_scl[0], scl_in};
    s_sda <= {s_sda[0], sda_in};
    if (!s_scl[1] && s_scl[0])
      shift <= {shift[6:0], s_sda[0]};
    if (!reset_n)
    begin
      nfall <= 4'hF;
      addr <= 8'h00;
    end
    else if (s_scl[1] && s_scl[0] && s_sda[1] && !s_sda[0])
      nfall <= 4'h0;
    else if (s_scl[1] && !s_scl[0] && nfall != 4'hF)
    begin
      nfall <= nfall + 4'h1;
      if (nfall == 4'h8)
        addr <= shift;
    end
  end
  AST_SDA_OPEN_DRAIN: assert property (!sda_out)
    else $error("data pin driven high");
  AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
    else $error("data changed while clock high");
  AST_HELD_QUIET: assert property (device_held |-> !sda_oe)
    else $error("slave drove data while held");
  AST_POR_RELEASE: assert property (!por_active [*8] |-> !device_held)
    else $error("still held after power-on reset ended");
  AST_NO_DRIVE_EARLY: assert property (nfall < 4'h8 |-> !sda_oe)
    else $error("slave drove data during address byte");
  AST_ACK_ONLY_OWN: assert property (nfall >= 4'h9 && addr[7:1] != `SLAVE_ADDR |-> !sda_oe)
    else $error("slave answered a foreign address");
  AST_ACK_OWN: assert property ($changed(nfall) && nfall == 4'h9 && addr[7:1] == `SLAVE_ADDR
    && !device_held |-> ##[0:4] sda_oe)
    else $error("own address not acknowledged");
  AST_ACK_RELEASE: assert property (nfall == 4'hA && !addr[0] |-> ##[0:5] !sda_oe)
    else $error("acknowledge not released");
  AST_OE_BOUNDED: assert property ($rose(sda_oe) |-> ##[1:600] !sda_oe)
    else $error("data held low too long");
  cover property ($fell(device_held) && por_active);
  cover property ($fell(alarm_int_n));
  cover property ($fell(square_wave_oe));
  cover property (nfall == 4'h9 && addr[7:1] != `SLAVE_ADDR);
endmodule
bind rtc_alarm_i2c rtc_alarm_i2c_checker #(.FIFO_DEPTH(FIFO_DEPTH), .OVR_COUNT(OVR_COUNT)) u_chk (
  .clk(clk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .square_wave_in(square_wave_in), .square_wave_out(square_wave_out),
  .square_wave_oe(square_wave_oe), .tick_64hz(tick_64hz), .por_active(por_active),
  .device_held(device_held), .alarm_int_n(alarm_int_n));
`default_nettype wire

// ### sim/i2c_master_model.sv
`default_nettype none
// bus master: only pulls lines low, the pull-ups make the highs
module i2c_master_model (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl_pull,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  // half bit of ten clocks leaves room for the slave's synchronisers
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one clock pulse; data released at the fall, set mid-low, sampled at end of high
  task automatic bit_io(input logic b, output logic r);
    scl_pull = 1'b1;
    sda_pull = 1'b0;
    w(5);
    sda_pull = !b;
    w(5);
    scl_pull = 1'b0;
    w(10);
    r = sda_line;
  endtask
  // start and repeated start alike
  task automatic start();
    scl_pull = 1'b1;
    w(10);
    scl_pull = 1'b0;
    w(10);
    sda_pull = 1'b1;
    w(10);
  endtask
  task automatic stop();
    scl_pull = 1'b1;
    sda_pull = 1'b1;
    w(10);
    scl_pull = 1'b0;
    w(10);
    sda_pull = 1'b0;
    w(20);
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack_n);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], ack_n);
    bit_io(1'b1, ack_n);
  endtask
  // last byte is refused so the slave lets go of the line
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++)
    begin
      bit_io(1'b1, r);
      d = {d[6:0], r};
    end
    bit_io(last, r);
  endtask
  // data held low across a run of clock pulses
  task automatic ovr(input int n);
    sda_pull = 1'b1;
    w(10);
    repeat (n)
    begin
      scl_pull = 1'b1;
      w(5);
      scl_pull = 1'b0;
      w(5);
    end
    sda_pull = 1'b0;
    w(10);
  endtask
endmodule
`default_nettype wire

// ### sim/rtc_alarm_i2c_tb.sv
`default_nettype none
module rtc_alarm_i2c_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, reset_n, square_wave_in, tick_64hz, por_active, sda_out, sda_oe;
  logic square_wave_out, square_wave_oe, device_held, alarm_int_n;
  logic scl_pull, sda_pull, scl_line, sda_line, a;
  logic [31:0] q;
  int num_errors = 0;
  int compares = 0;
  // open-drain lines with pull-ups
  assign scl_line = !scl_pull;
  assign sda_line = !sda_pull && !(sda_oe && !sda_out);
  rtc_alarm_i2c #(.FIFO_DEPTH(4), .OVR_COUNT(4)) u_dut (.clk(clk), .reset_n(reset_n),
    .scl_in(scl_line), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .square_wave_in(square_wave_in), .square_wave_out(square_wave_out),
    .square_wave_oe(square_wave_oe), .tick_64hz(tick_64hz), .por_active(por_active),
    .device_held(device_held), .alarm_int_n(alarm_int_n));
  i2c_master_model u_m (.clk(clk), .sda_line(sda_line), .scl_pull(scl_pull),
    .sda_pull(sda_pull));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // slow internal tick; ignored once the pin clocks the pre-scaler
  initial
  begin
    tick_64hz = 1'b0;
    forever
    begin
      repeat (400) @(negedge clk);
      tick_64hz = ~tick_64hz;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask
  // pointer byte, then n data bytes taken from the top of d
  task automatic wr(input logic [7:0] p, input logic [31:0] d, input int n);
    u_m.start();
    u_m.put_byte(8'hA2, a);
    chk("address ack", 32'h0, {31'h0, a});
    u_m.put_byte(p, a);
    chk("pointer ack", 32'h0, {31'h0, a});
    for (int i = 0; i < n; i++)
    begin
      u_m.put_byte(d[31 - 8 * i -: 8], a);
      chk("data ack", 32'h0, {31'h0, a});
    end
    u_m.stop();
  endtask
  // reads start at the pointer left by the previous write
  task automatic rd(input logic [7:0] p, input int n, output logic [31:0] d);
    logic [7:0] b;
    d = 32'h0;
    wr(p, 32'h0, 0);
    u_m.start();
    u_m.put_byte(8'hA3, a);
    chk("read address ack", 32'h0, {31'h0, a});
    for (int i = 0; i < n; i++)
    begin
      u_m.get_byte(i == n - 1, b);
      d = {d[23:0], b};
    end
    u_m.stop();
  endtask
  task automatic pulse(input int n);
    repeat (n)
    begin
      square_wave_in = 1'b1;
      wait_clk(8);
      square_wave_in = 1'b0;
      wait_clk(8);
    end
  endtask
  task automatic t_override();
    chk("held at start", 32'h1, {31'h0, device_held});
    u_m.ovr(4);
    wait_clk(10);
    chk("held after override", 32'h0, {31'h0, device_held});
    $display("test override done");
  endtask
  // reserved test addresses 49h and 4Ah are never touched
  task automatic t_regs();
    wr(8'h09, 32'hFFFF_FFFF, 4);
    rd(8'h09, 4, q);
    chk("alarm fields", 32'hFFBF_BF87, q);
    rd(8'h0D, 1, q);
    chk("unmapped read", 32'h0, q);
    u_m.start();
    u_m.put_byte(8'hA4, a);
    chk("foreign address ack", 32'h1, {31'h0, a});
    u_m.stop();
    $display("test registers done");
  endtask
  // pre-scaler content is unknown on entry, so stop clears it first
  task automatic t_tick();
    wr(8'h00, 32'hA800_0000, 1);
    wait_clk(10);
    chk("pin direction", 32'h0, {31'h0, square_wave_oe});
    pulse(10);
    wr(8'h00, 32'h8800_0000, 1);
    wr(8'h02, 32'h5804_0001, 4);
    wr(8'h09, 32'h05A2_8180, 4);
    wr(8'h01, 32'h0200_0000, 1);
    pulse(31);
    rd(8'h01, 2, q);
    chk("31 edges", 32'h0258, q & 32'h0A7F);
    pulse(1);
    rd(8'h02, 1, q);
    chk("32 edges", 32'h59, q & 32'h7F);
    pulse(63);
    rd(8'h02, 1, q);
    chk("95 edges", 32'h59, q & 32'h7F);
    pulse(1);
    rd(8'h01, 3, q);
    chk("rollover and flag", 32'h0A0005, q & 32'h0A7F7F);
    chk("interrupt low", 32'h0, {31'h0, alarm_int_n});
    wr(8'h01, 32'h0A00_0000, 1);
    rd(8'h01, 1, q);
    chk("flag kept", 32'h0A, q & 32'h0A);
    wr(8'h01, 32'h0200_0000, 1);
    rd(8'h01, 1, q);
    chk("flag cleared", 32'h02, q & 32'h0A);
    chk("interrupt high", 32'h1, {31'h0, alarm_int_n});
    $display("test tick and alarm done");
  endtask
  task automatic t_permit();
    // the hold returns while this byte is acknowledged, so it is refused
    u_m.start();
    u_m.put_byte(8'hA2, a);
    chk("permit address ack", 32'h0, {31'h0, a});
    u_m.put_byte(8'h00, a);
    chk("permit pointer ack", 32'h0, {31'h0, a});
    u_m.put_byte(8'h00, a);
    chk("nack once held again", 32'h1, {31'h0, a});
    u_m.stop();
    wait_clk(10);
    chk("held after cancel", 32'h1, {31'h0, device_held});
    u_m.ovr(4);
    wait_clk(10);
    chk("override blocked", 32'h1, {31'h0, device_held});
    por_active = 1'b0;
    wait_clk(10);
    chk("released", 32'h0, {31'h0, device_held});
    chk("pin output", 32'h1, {31'h0, square_wave_oe});
    @(posedge tick_64hz);
    wait_clk(5);
    chk("square wave copy", 32'h1, {31'h0, square_wave_out});
    $display("test permit done");
  endtask
  task automatic summarize();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    reset_n = 1'b0;
    square_wave_in = 1'b0;
    por_active = 1'b1;
    wait_clk(2);
    reset_n = 1'b1;
    wait_clk(10);
    t_override();
    t_regs();
    t_tick();
    t_permit();
    summarize();
  end
  // the tests need well under half of this
  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    $display("timeout waiting for the tests");
    summarize();
  end
endmodule
`default_nettype wire
